/* File: hdl/pwm_timer_pkg.sv */
// shared types and constants for the match based pwm timer
package pwm_timer_pkg;
    localparam int COUNT_WIDTH = 32;
    localparam int MATCH_COUNT = 7;
    localparam int OUT_COUNT = 6;
    localparam int PERIOD_IDX = 0;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_STEP = 32'h0000_0001;

    // per match register action bits
    typedef struct packed {
        logic irq_en;
        logic reset_en;
        logic stop_en;
    } match_ctrl_type;

    // per output configuration
    typedef struct packed {
        logic double_edge;
        logic out_en;
    } out_ctrl_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_STOPPED
    } run_state_type;
endpackage

/* File: hdl/match_shadow.sv */
// one match register with shadow and release-gated transfer
`timescale 1ns/100ps
module match_shadow #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // software side
    input wire logic wr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic release_in,
    input wire logic apply_in,
    // compare side
    input wire logic [WIDTH-1:0] count_in,
    input wire logic tick_in,
    output logic [WIDTH-1:0] value_out,
    output logic hit_out
);
    logic [WIDTH-1:0] shadow_ff, nxt_shadow;
    logic [WIDTH-1:0] active_ff, nxt_active;
    logic pending_ff, nxt_pending;

    always_comb begin
        nxt_shadow = shadow_ff;
        nxt_active = active_ff;
        nxt_pending = pending_ff;
        if (wr_in) begin
            nxt_shadow = wr_data_in;
        end
        if (release_in) begin
            nxt_pending = 1'b1;
        end
        if (apply_in && pending_ff) begin
            nxt_active = shadow_ff;
            nxt_pending = release_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shadow_ff <= '0;
            active_ff <= '0;
            pending_ff <= 1'b0;
        end else begin
            shadow_ff <= nxt_shadow;
            active_ff <= nxt_active;
            pending_ff <= nxt_pending;
        end
    end

    assign value_out = active_ff;
    assign hit_out = tick_in && (count_in == active_ff);
endmodule

/* File: hdl/match_pwm_timer.sv */
// match based pwm timer with prescaler, seven match registers and six outputs
// Operation
// - a 32-bit counter counts clock cycles after a programmable 32-bit prescaler
// - seven match registers compare against the counter and act on equality
// - in pwm mode period match always resets the counter and so sets the cycle rate
// - each single-edge output uses one more match register for its edge
// - single-edge outputs go high at period match unless held constantly low
// - a double-edge output uses two match registers besides the period one
// - rising before falling gives a high pulse, reversed gives a low pulse
// - double-edge edges may sit at any counter position in the cycle
// - up to six single-edge, three double-edge outputs, or a mix
// - each match may independently interrupt, stop or reset the timer
// - period and width are any count; all outputs share one rate
// - match values apply only after software releases them, in step with outputs
// - without pwm mode the block is a plain timer, outputs not edge driven
`timescale 1ns/100ps
module match_pwm_timer #(
    parameter int COUNT_WIDTH = pwm_timer_pkg::COUNT_WIDTH,
    parameter int MATCH_COUNT = pwm_timer_pkg::MATCH_COUNT
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // control
    input wire logic count_en_in,
    input wire logic count_clear_in,
    input wire logic pwm_mode_in,
    input wire logic [COUNT_WIDTH-1:0] prescale_in,
    input wire pwm_timer_pkg::match_ctrl_type [MATCH_COUNT-1:0] match_ctrl_in,
    input wire pwm_timer_pkg::out_ctrl_type [MATCH_COUNT-1:1] out_ctrl_in,
    // match value writes
    input wire logic [MATCH_COUNT-1:0] match_wr_in,
    input wire logic [COUNT_WIDTH-1:0] match_data_in,
    input wire logic [MATCH_COUNT-1:0] match_release_in,
    // status
    output logic [COUNT_WIDTH-1:0] count_out,
    output logic [COUNT_WIDTH-1:0] prescale_count_out,
    output logic running_out,
    output logic [MATCH_COUNT-1:0] match_event_out,
    output logic irq_out,
    // pwm pins
    output logic [MATCH_COUNT-1:1] pwm_out
);
    // elaboration check on the widths and counts the logic can serve
    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 32 || MATCH_COUNT < 2 || MATCH_COUNT > 7) begin : g_bad_params
        $error("match_pwm_timer: unsupported parameters");
    end

    localparam logic [COUNT_WIDTH-1:0] ZERO = COUNT_WIDTH'(pwm_timer_pkg::COUNT_RESET);
    localparam logic [COUNT_WIDTH-1:0] ONE = COUNT_WIDTH'(pwm_timer_pkg::COUNT_STEP);

    pwm_timer_pkg::run_state_type state_ff, nxt_state;
    logic [COUNT_WIDTH-1:0] tc_ff, nxt_tc;
    logic [COUNT_WIDTH-1:0] pc_ff, nxt_pc;
    logic [MATCH_COUNT-1:0] event_ff, nxt_event;
    logic irq_ff, nxt_irq;
    logic [MATCH_COUNT-1:1] pwm_ff, nxt_pwm;
    logic tick;
    logic [MATCH_COUNT-1:0] hit;
    logic period_hit;

    assign tick = (state_ff == pwm_timer_pkg::ST_RUN) && (pc_ff == prescale_in);
    assign period_hit = hit[pwm_timer_pkg::PERIOD_IDX];

    genvar gi;
    generate
        for (gi = 0; gi < MATCH_COUNT; gi++) begin : g_match
            match_shadow #(
                .WIDTH(COUNT_WIDTH)
            ) u_match (
                .sys_clk_in(sys_clk_in),
                .resetn_in(resetn_in),
                .wr_in(match_wr_in[gi]),
                .wr_data_in(match_data_in),
                .release_in(match_release_in[gi]),
                .apply_in(period_hit || state_ff != pwm_timer_pkg::ST_RUN),
                .count_in(tc_ff),
                .tick_in(tick),
                .value_out(),
                .hit_out(hit[gi])
            );
        end
    endgenerate

    // counter and run state
    always_comb begin
        logic do_reset;
        logic do_stop;
        do_reset = 1'b0;
        do_stop = 1'b0;
        nxt_state = state_ff;
        nxt_tc = tc_ff;
        nxt_pc = pc_ff;
        for (int i = 0; i < MATCH_COUNT; i++) begin
            if (hit[i] && match_ctrl_in[i].reset_en) begin
                do_reset = 1'b1;
            end
            if (hit[i] && match_ctrl_in[i].stop_en) begin
                do_stop = 1'b1;
            end
        end
        if (pwm_mode_in && period_hit) begin
            do_reset = 1'b1;
        end
        case (state_ff)
            pwm_timer_pkg::ST_IDLE: begin
                if (count_en_in) begin
                    nxt_state = pwm_timer_pkg::ST_RUN;
                end
            end
            pwm_timer_pkg::ST_RUN: begin
                if (!count_en_in) begin
                    nxt_state = pwm_timer_pkg::ST_IDLE;
                end else if (do_stop) begin
                    nxt_state = pwm_timer_pkg::ST_STOPPED;
                end
                if (tick) begin
                    nxt_pc = ZERO;
                    nxt_tc = do_reset ? ZERO : tc_ff + ONE;
                end else begin
                    nxt_pc = pc_ff + ONE;
                end
            end
            pwm_timer_pkg::ST_STOPPED: begin
                if (!count_en_in) begin
                    nxt_state = pwm_timer_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = pwm_timer_pkg::ST_IDLE;
            end
        endcase
        if (count_clear_in) begin
            nxt_tc = ZERO;
            nxt_pc = ZERO;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= pwm_timer_pkg::ST_IDLE;
            tc_ff <= '0;
            pc_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            tc_ff <= nxt_tc;
            pc_ff <= nxt_pc;
        end
    end

    // match events and interrupt
    always_comb begin
        nxt_irq = 1'b0;
        nxt_event = hit;
        for (int i = 0; i < MATCH_COUNT; i++) begin
            if (hit[i] && match_ctrl_in[i].irq_en) begin
                nxt_irq = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            event_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            event_ff <= nxt_event;
            irq_ff <= nxt_irq;
        end
    end

    // pwm output edges
    always_comb begin
        nxt_pwm = pwm_ff;
        for (int n = 1; n < MATCH_COUNT; n++) begin
            if (!pwm_mode_in || !out_ctrl_in[n].out_en) begin
                nxt_pwm[n] = 1'b0;
            end else if (out_ctrl_in[n].double_edge && n >= 2) begin
                // set by match n-1, clear by match n
                // order of the two matches picks pulse polarity
                if (hit[n-1] && !hit[n]) begin
                    nxt_pwm[n] = 1'b1;
                end else if (hit[n] && !hit[n-1]) begin
                    nxt_pwm[n] = 1'b0;
                end
            end else begin
                // own match sets the falling edge
                if (hit[n]) begin
                    nxt_pwm[n] = 1'b0;
                end else if (period_hit) begin
                    nxt_pwm[n] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pwm_ff <= '0;
        end else begin
            pwm_ff <= nxt_pwm;
        end
    end

    // outputs 1..6 share the match set
    // one period match for all outputs
    assign pwm_out = pwm_ff;
    assign count_out = tc_ff;
    assign prescale_count_out = pc_ff;
    assign running_out = (state_ff == pwm_timer_pkg::ST_RUN);
    assign match_event_out = event_ff;
    assign irq_out = irq_ff;
endmodule

/* File: verif/match_pwm_timer_properties.sv */
// port level checks for the match based pwm timer
`timescale 1ns/100ps
module match_pwm_timer_properties #(
    parameter int COUNT_WIDTH = 32,
    parameter int MATCH_COUNT = 7
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // control
    input wire logic pwm_mode_in,
    input wire logic [COUNT_WIDTH-1:0] prescale_in,
    input wire pwm_timer_pkg::match_ctrl_type [MATCH_COUNT-1:0] match_ctrl_in,
    input wire pwm_timer_pkg::out_ctrl_type [MATCH_COUNT-1:1] out_ctrl_in,
    // status and pins
    input wire logic [COUNT_WIDTH-1:0] count_out,
    input wire logic [COUNT_WIDTH-1:0] prescale_count_out,
    input wire logic running_out,
    input wire logic [MATCH_COUNT-1:0] match_event_out,
    input wire logic [MATCH_COUNT-1:1] pwm_out
);
    logic [MATCH_COUNT-1:0] stop_bits;
    always_comb begin
        for (int i = 0; i < MATCH_COUNT; i++) begin
            stop_bits[i] = match_ctrl_in[i].stop_en;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_mode_off;
        !pwm_mode_in ##1 !pwm_mode_in;
    endsequence
    sequence s_step;
        count_out == $past(count_out) + 1'b1;
    endsequence
    property p_mode_off;
        s_mode_off |-> pwm_out == '0;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("pins driven in timer mode");
    property p_prescale;
        s_step |-> $past(prescale_count_out) == $past(prescale_in);
    endproperty
    a_prescale: assert property (p_prescale) else $error("count stepped early");
    property p_period;
        match_event_out[0] && $past(pwm_mode_in) |-> count_out == '0;
    endproperty
    a_period: assert property (p_period) else $error("no wrap on period");
    property p_s_rise;
        match_event_out[0] && !match_event_out[1]
            && $past(pwm_mode_in && out_ctrl_in[1].out_en) |-> pwm_out[1];
    endproperty
    a_s_rise: assert property (p_s_rise) else $error("single not set");
    property p_s_fall;
        match_event_out[1] && $past(pwm_mode_in) |-> !pwm_out[1];
    endproperty
    a_s_fall: assert property (p_s_fall) else $error("single not cleared");
    property p_d_rise;
        match_event_out[1] && !match_event_out[2] && $past(pwm_mode_in
            && out_ctrl_in[2].double_edge && out_ctrl_in[2].out_en) |-> pwm_out[2];
    endproperty
    a_d_rise: assert property (p_d_rise) else $error("double not set");
    property p_d_fall;
        match_event_out[2] && $past(pwm_mode_in && out_ctrl_in[2].double_edge) |-> !pwm_out[2];
    endproperty
    a_d_fall: assert property (p_d_fall) else $error("double not cleared");
    property p_stop;
        |(match_event_out & $past(stop_bits)) |-> !running_out;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop on match");
endmodule

/* File: verif/pwm_load_model.sv */
// load model that tallies high cycles on each pwm pin
`timescale 1ns/100ps
module pwm_load_model (
    // clock and window
    input wire logic sys_clk_in,
    input wire logic clear_in,
    input wire logic window_in,
    // pins and tallies
    input wire logic [6:1] pwm_in,
    output logic [6:1][7:0] high_cnt_out
);
    always_ff @(posedge sys_clk_in) begin
        for (int i = 1; i <= 6; i++) begin
            if (clear_in) begin
                high_cnt_out[i] <= 8'h0;
            end else if (window_in && pwm_in[i]) begin
                high_cnt_out[i] <= high_cnt_out[i] + 8'h1;
            end
        end
    end
endmodule

/* File: verif/match_pwm_timer_bench.sv */
// self-checking bench for the match based pwm timer
`timescale 1ns/100ps
module match_pwm_timer_bench;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic count_en_in = 1'b0;
    logic count_clear_in = 1'b0;
    logic pwm_mode_in = 1'b0;
    logic [31:0] prescale_in = 32'h0;
    pwm_timer_pkg::match_ctrl_type [6:0] match_ctrl_in = '0;
    pwm_timer_pkg::out_ctrl_type [6:1] out_ctrl_in = '0;
    logic [6:0] match_wr_in = 7'h0;
    logic [31:0] match_data_in = 32'h0;
    logic [6:0] match_release_in = 7'h0;
    logic [31:0] count_out, prescale_count_out, c;
    logic running_out, irq_out, ld_clr = 1'b0, ld_win = 1'b0;
    logic [6:0] match_event_out;
    logic [6:1] pwm_out;
    logic [6:1][7:0] high;
    int n_fail = 0, checks_done = 0, cycles = 0, irqs = 0;
    match_pwm_timer dut (.sys_clk_in, .resetn_in, .count_en_in, .count_clear_in,
        .pwm_mode_in, .prescale_in, .match_ctrl_in, .out_ctrl_in, .match_wr_in,
        .match_data_in, .match_release_in, .count_out, .prescale_count_out,
        .running_out, .match_event_out, .irq_out, .pwm_out);
    pwm_load_model load (.sys_clk_in, .clear_in(ld_clr), .window_in(ld_win),
        .pwm_in(pwm_out), .high_cnt_out(high));
    initial forever #2 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cycles++;
        if (ld_win && irq_out === 1'b1) irqs++;
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic put_match(input int idx, input logic [31:0] val);
        match_wr_in[idx] = 1'b1;
        match_data_in = val;
        step(1);
        match_wr_in = 7'h0;
        match_release_in[idx] = 1'b1;
        step(1);
        match_release_in = 7'h0;
    endtask
    // tally each pin over n clocks
    task automatic loads(input int n, input logic [6:1][7:0] exp);
        ld_clr = 1'b1;
        step(1);
        ld_clr = 1'b0;
        ld_win = 1'b1;
        irqs = 0;
        step(n);
        ld_win = 1'b0;
        for (int i = 1; i <= 6; i++) check($sformatf("pin %0d", i), high[i], exp[i]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        step(5);
        resetn_in = 1'b1;
        step(1);
        pwm_mode_in = 1'b1;
        out_ctrl_in = {2'b00, 2'b01, 2'b11, 2'b01, 2'b11, 2'b01};
        match_ctrl_in[6].irq_en = 1'b1;
        put_match(0, 32'h9);
        put_match(1, 32'h2);
        put_match(2, 32'h5);
        put_match(3, 32'h7);
        put_match(4, 32'h1);
        put_match(5, 32'h4);
        put_match(6, 32'h6);
        count_en_in = 1'b1;
        step(30);
        loads(50, {8'h00, 8'h19, 8'h14, 8'h28, 8'h0F, 8'h0F});
        check("irq count", irqs, 32'h5);
        $display("mixed outputs done");
        // unreleased write must not reach the compare
        match_wr_in[5] = 1'b1;
        match_data_in = 32'h8;
        step(1);
        match_wr_in = 7'h0;
        step(20);
        loads(50, {8'h00, 8'h19, 8'h14, 8'h28, 8'h0F, 8'h0F});
        put_match(5, 32'h8);
        step(20);
        loads(50, {8'h00, 8'h2D, 8'h14, 8'h28, 8'h0F, 8'h0F});
        $display("release done");
        prescale_in = 32'h2;
        step(60);
        loads(60, {8'h00, 8'h36, 8'h18, 8'h30, 8'h12, 8'h12});
        $display("prescale done");
        prescale_in = 32'h0;
        pwm_mode_in = 1'b0;
        count_clear_in = 1'b1;
        step(1);
        count_clear_in = 1'b0;
        step(2);
        c = count_out;
        step(4);
        check("timer count", count_out, c + 32'h4);
        loads(20, '0);
        match_ctrl_in[6].stop_en = 1'b1;
        count_clear_in = 1'b1;
        step(1);
        count_clear_in = 1'b0;
        step(20);
        check("running", {31'h0, running_out}, 32'h0);
        c = count_out;
        step(3);
        check("held count", count_out, c);
        match_ctrl_in[6].stop_en = 1'b0;
        match_ctrl_in[3].reset_en = 1'b1;
        count_en_in = 1'b0;
        step(1);
        count_en_in = 1'b1;
        for (int i = 0; i < 14; i++) begin
            step(1);
            check("reset bound", {31'h0, count_out <= 32'h7}, 32'h1);
        end
        $display("timer mode done");
        report_and_stop();
    end
endmodule
bind match_pwm_timer match_pwm_timer_properties #(
    .COUNT_WIDTH(COUNT_WIDTH),
    .MATCH_COUNT(MATCH_COUNT)
) props (.sys_clk_in, .resetn_in, .pwm_mode_in, .prescale_in, .match_ctrl_in,
    .out_ctrl_in, .count_out, .prescale_count_out, .running_out, .match_event_out,
    .pwm_out);
